// ==== hdl/tcc_pkg.sv ====
// Constants of the four-channel timer flag, enable and compare block
package tcc_pkg;
    localparam int ADDR_W = 8;
    localparam int REG_W = 16;
    localparam int FLAG_W = 5;
    localparam int CLR_W = 3;
    // Address layout: one block of eight words per channel, run word above
    localparam int CH_LSB = 5;
    localparam int OFF_LSB = 2;
    localparam logic [ADDR_W-1:0] RUN_ADDR = 8'h80;
    localparam int GLOBAL_BIT = 7;
    localparam logic [2:0] OFF_IRQ_EN = 3'h0;
    localparam logic [2:0] OFF_FLAGS = 3'h1;
    localparam logic [2:0] OFF_COUNTER = 3'h2;
    localparam logic [2:0] OFF_CMP_A = 3'h3;
    localparam logic [2:0] OFF_CMP_B = 3'h4;
    localparam logic [2:0] OFF_CMP_C = 3'h5;
    localparam logic [2:0] OFF_CMP_D = 3'h6;
    localparam logic [2:0] OFF_CTRL = 3'h7;
    // Flag and enable bit positions
    localparam int BIT_MATCH_A = 0;
    localparam int BIT_MATCH_B = 1;
    localparam int BIT_MATCH_C = 2;
    localparam int BIT_MATCH_D = 3;
    localparam int BIT_OVERFLOW = 4;
    // Control word fields
    localparam int CTRL_BUF_A_BIT = 0;
    localparam int CTRL_BUF_B_BIT = 1;
    localparam int CTRL_CLR_LSB = 4;
    localparam logic [CLR_W-1:0] CLR_NONE = 3'h0;
    localparam logic [CLR_W-1:0] CLR_BY_A = 3'h1;
    localparam logic [CLR_W-1:0] CLR_BY_B = 3'h2;
    localparam logic [CLR_W-1:0] CLR_BY_C = 3'h3;
    localparam logic [CLR_W-1:0] CLR_BY_D = 3'h4;
    // Reset values, counter top and count step
    localparam logic [REG_W-1:0] COUNTER_RESET = 16'h0000;
    localparam logic [REG_W-1:0] COMPARE_RESET = 16'hFFFF;
    localparam logic [REG_W-1:0] COUNTER_TOP = 16'hFFFF;
    localparam logic [REG_W-1:0] COUNTER_ONE = 16'h0001;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== hdl/tcc_timer.sv ====
// Timer channels: counters, compare registers, flags and interrupt gating
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns

// Summary of operation
// [R1] Bits 15..5 of enable/flags read zero
// [R2] Enable bit 4 gates overflow flag interrupt
// [R3] Enable bit 3 gates match D interrupt
// [R4] Enable bit 2 gates match C interrupt
// [R5] Enable bit 1 gates match B interrupt
// [R6] Enable bit 0 gates match A interrupt
// [R7] Flag bit 4 sets on counter wrap
// [R8] Overflow flag clears by zero after read
// [R9] Flag bit 3 sets on D match
// [R10] Flag bit 2 sets on C match
// [R11] Flag bit 1 sets on B match
// [R12] Flag bit 0 sets on A match
// [R13] Writing one to a flag does nothing
// [R14] Counter sixteen bits, resets to zero
// [R15] Compare registers sixteen bits, reset all ones
// [R16] Registers C and D may act as buffers
// [R17] C buffers A, D buffers B only
// [R18] Counter advances only while run bit set
// [R19] Selected match clears counter to zero
// [R20] Buffer copies into partner on match
// [R21] Interrupt high while enabled flag set
module tcc_timer #(
    parameter int NUM_CH = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic countTick,
    input wire logic [tcc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tcc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [NUM_CH-1:0] channelIrq,
    output logic [NUM_CH-1:0] channelRun,
    output logic [NUM_CH*tcc_pkg::FLAG_W-1:0] channelEvent
);
    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
        $error("NUM_CH must lie between 1 and 4");
    end

    typedef struct packed {
        logic [NUM_CH-1:0][tcc_pkg::REG_W-1:0] cnt;
        logic [NUM_CH-1:0][tcc_pkg::REG_W-1:0] cmpA;
        logic [NUM_CH-1:0][tcc_pkg::REG_W-1:0] cmpB;
        logic [NUM_CH-1:0][tcc_pkg::REG_W-1:0] cmpC;
        logic [NUM_CH-1:0][tcc_pkg::REG_W-1:0] cmpD;
        logic [NUM_CH-1:0][tcc_pkg::FLAG_W-1:0] irqEn;
        logic [NUM_CH-1:0][tcc_pkg::FLAG_W-1:0] flags;
        logic [NUM_CH-1:0][tcc_pkg::FLAG_W-1:0] seen;
        logic [NUM_CH-1:0][tcc_pkg::FLAG_W-1:0] events;
        logic [NUM_CH-1:0][tcc_pkg::CLR_W-1:0] clrSel;
        logic [NUM_CH-1:0] bufA;
        logic [NUM_CH-1:0] bufB;
        logic [NUM_CH-1:0] run;
        logic [NUM_CH-1:0] irq;
        logic awHeld;
        logic wHeld;
        logic awRdy;
        logic wRdy;
        logic arRdy;
        logic bValid;
        logic rValid;
        logic [tcc_pkg::ADDR_W-1:0] awAddr;
        logic [tcc_pkg::ADDR_W-1:0] arAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic [1:0] bResp;
        logic [1:0] rResp;
        logic [31:0] rData;
    } tcc_state_t;

    localparam tcc_state_t ST_RESET = '{
        cmpA: {NUM_CH{tcc_pkg::COMPARE_RESET}},
        cmpB: {NUM_CH{tcc_pkg::COMPARE_RESET}},
        cmpC: {NUM_CH{tcc_pkg::COMPARE_RESET}},
        cmpD: {NUM_CH{tcc_pkg::COMPARE_RESET}},
        cnt: {NUM_CH{tcc_pkg::COUNTER_RESET}},
        default: '0
    };

    tcc_state_t stateReg;
    tcc_state_t stateNext;

    // Byte-lane merge for the sixteen-bit registers
    function automatic logic [tcc_pkg::REG_W-1:0] mergeLanes(
        input logic [tcc_pkg::REG_W-1:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        return {strb[1] ? data[15:8] : old[15:8],
            strb[0] ? data[7:0] : old[7:0]};
    endfunction

    logic doWr, wrGlobal, wrOk, rdGlobal, doRd;
    logic [1:0] wrCh, rdCh;
    logic [2:0] wrOff, rdOff;

    assign doWr = stateReg.awHeld && stateReg.wHeld && !stateReg.bValid;
    assign wrGlobal = stateReg.awAddr[tcc_pkg::ADDR_W-1:tcc_pkg::OFF_LSB]
        == tcc_pkg::RUN_ADDR[tcc_pkg::ADDR_W-1:tcc_pkg::OFF_LSB];
    assign wrCh = stateReg.awAddr[tcc_pkg::CH_LSB+1:tcc_pkg::CH_LSB];
    assign wrOff = stateReg.awAddr[tcc_pkg::CH_LSB-1:tcc_pkg::OFF_LSB];
    assign wrOk = wrGlobal || (!stateReg.awAddr[tcc_pkg::GLOBAL_BIT]
        && int'(wrCh) < NUM_CH);
    assign doRd = s_axi_arvalid && stateReg.arRdy;
    assign rdGlobal = s_axi_araddr[tcc_pkg::ADDR_W-1:tcc_pkg::OFF_LSB]
        == tcc_pkg::RUN_ADDR[tcc_pkg::ADDR_W-1:tcc_pkg::OFF_LSB];
    assign rdCh = s_axi_araddr[tcc_pkg::CH_LSB+1:tcc_pkg::CH_LSB];
    assign rdOff = s_axi_araddr[tcc_pkg::CH_LSB-1:tcc_pkg::OFF_LSB];

    always_comb begin
        logic tick, clr, ovf, chWr, chRd;
        logic [3:0] eq;
        logic [tcc_pkg::FLAG_W-1:0] evt;
        logic [tcc_pkg::FLAG_W-1:0] clrMask;
        logic [tcc_pkg::REG_W-1:0] cur;
        tick = 1'b0;
        clr = 1'b0;
        ovf = 1'b0;
        chWr = 1'b0;
        chRd = 1'b0;
        eq = '0;
        evt = '0;
        clrMask = '0;
        cur = '0;
        stateNext = stateReg;
        if (s_axi_awvalid && stateReg.awRdy) begin
            stateNext.awHeld = 1'b1;
            stateNext.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && stateReg.wRdy) begin
            stateNext.wHeld = 1'b1;
            stateNext.wData = s_axi_wdata;
            stateNext.wStrb = s_axi_wstrb;
        end
        if (doWr) begin
            stateNext.awHeld = 1'b0;
            stateNext.wHeld = 1'b0;
            stateNext.bValid = 1'b1;
            stateNext.bResp = wrOk ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
        end
        if (stateReg.bValid && s_axi_bready) begin
            stateNext.bValid = 1'b0;
        end
        if (doWr && wrGlobal && stateReg.wStrb[0]) begin
            stateNext.run = stateReg.wData[NUM_CH-1:0];
        end
        if (stateReg.rValid && s_axi_rready) begin
            stateNext.rValid = 1'b0;
        end
        if (doRd) begin
            stateNext.rValid = 1'b1;
            stateNext.arAddr = s_axi_araddr;
            stateNext.rResp = tcc_pkg::RESP_OKAY;
            stateNext.rData = '0;
            if (rdGlobal) begin
                stateNext.rData = 32'(stateReg.run);
            end else if (s_axi_araddr[tcc_pkg::GLOBAL_BIT]
                || int'(rdCh) >= NUM_CH) begin
                stateNext.rResp = tcc_pkg::RESP_SLVERR;
            end else if (rdOff == tcc_pkg::OFF_IRQ_EN) begin
                stateNext.rData = 32'(stateReg.irqEn[rdCh]); // R1
            end else if (rdOff == tcc_pkg::OFF_FLAGS) begin
                stateNext.rData = 32'(stateReg.flags[rdCh]); // R1
            end else if (rdOff == tcc_pkg::OFF_COUNTER) begin
                stateNext.rData = 32'(stateReg.cnt[rdCh]);
            end else if (rdOff == tcc_pkg::OFF_CMP_A) begin
                stateNext.rData = 32'(stateReg.cmpA[rdCh]);
            end else if (rdOff == tcc_pkg::OFF_CMP_B) begin
                stateNext.rData = 32'(stateReg.cmpB[rdCh]);
            end else if (rdOff == tcc_pkg::OFF_CMP_C) begin
                stateNext.rData = 32'(stateReg.cmpC[rdCh]);
            end else if (rdOff == tcc_pkg::OFF_CMP_D) begin
                stateNext.rData = 32'(stateReg.cmpD[rdCh]);
            end else begin
                stateNext.rData[tcc_pkg::CTRL_BUF_A_BIT] = stateReg.bufA[rdCh];
                stateNext.rData[tcc_pkg::CTRL_BUF_B_BIT] = stateReg.bufB[rdCh];
                stateNext.rData[tcc_pkg::CTRL_CLR_LSB+:tcc_pkg::CLR_W] =
                    stateReg.clrSel[rdCh];
            end
        end
        for (int c = 0; c < NUM_CH; c++) begin
            cur = stateReg.cnt[c];
            tick = stateReg.run[c] && countTick; // R18
            eq[0] = tick && cur == stateReg.cmpA[c];
            eq[1] = tick && cur == stateReg.cmpB[c];
            eq[2] = tick && cur == stateReg.cmpC[c];
            eq[3] = tick && cur == stateReg.cmpD[c];
            case (stateReg.clrSel[c])
                tcc_pkg::CLR_BY_A: clr = eq[0]; // R19
                tcc_pkg::CLR_BY_B: clr = eq[1]; // R19
                tcc_pkg::CLR_BY_C: clr = eq[2]; // R19
                tcc_pkg::CLR_BY_D: clr = eq[3]; // R19
                default: clr = 1'b0;
            endcase
            ovf = tick && !clr && cur == tcc_pkg::COUNTER_TOP; // R7
            // A register serving as buffer raises no match of its own
            evt = '0;
            evt[tcc_pkg::BIT_OVERFLOW] = ovf; // R7
            evt[tcc_pkg::BIT_MATCH_A] = eq[0]; // R12
            evt[tcc_pkg::BIT_MATCH_B] = eq[1]; // R11
            evt[tcc_pkg::BIT_MATCH_C] = eq[2] && !stateReg.bufA[c]; // R10
            evt[tcc_pkg::BIT_MATCH_D] = eq[3] && !stateReg.bufB[c]; // R9
            stateNext.events[c] = evt;
            if (clr) begin
                stateNext.cnt[c] = tcc_pkg::COUNTER_RESET; // R19
            end else if (tick) begin
                stateNext.cnt[c] = cur + tcc_pkg::COUNTER_ONE; // R14 R18
            end
            if (stateReg.bufA[c] && eq[0]) begin
                stateNext.cmpA[c] = stateReg.cmpC[c]; // R16 R17 R20
            end
            if (stateReg.bufB[c] && eq[1]) begin
                stateNext.cmpB[c] = stateReg.cmpD[c]; // R16 R17 R20
            end
            chWr = doWr && !wrGlobal && wrOk && int'(wrCh) == c;
            chRd = doRd && !rdGlobal && !s_axi_araddr[tcc_pkg::GLOBAL_BIT]
                && int'(rdCh) == c && rdOff == tcc_pkg::OFF_FLAGS;
            clrMask = '0;
            // Software writes to counter and compare registers win over counting and buffer transfer
            if (chWr) begin
                if (wrOff == tcc_pkg::OFF_IRQ_EN && stateReg.wStrb[0]) begin
                    stateNext.irqEn[c] =
                        stateReg.wData[tcc_pkg::FLAG_W-1:0]; // R1
                end else if (wrOff == tcc_pkg::OFF_FLAGS
                    && stateReg.wStrb[0]) begin
                    // Only zero bits that were read as one may clear
                    clrMask = ~stateReg.wData[tcc_pkg::FLAG_W-1:0]
                        & stateReg.seen[c]; // R8 R13
                end else if (wrOff == tcc_pkg::OFF_COUNTER) begin
                    stateNext.cnt[c] = mergeLanes(stateReg.cnt[c],
                        stateReg.wData, stateReg.wStrb);
                end else if (wrOff == tcc_pkg::OFF_CMP_A) begin
                    stateNext.cmpA[c] = mergeLanes(stateReg.cmpA[c],
                        stateReg.wData, stateReg.wStrb);
                end else if (wrOff == tcc_pkg::OFF_CMP_B) begin
                    stateNext.cmpB[c] = mergeLanes(stateReg.cmpB[c],
                        stateReg.wData, stateReg.wStrb);
                end else if (wrOff == tcc_pkg::OFF_CMP_C) begin
                    stateNext.cmpC[c] = mergeLanes(stateReg.cmpC[c],
                        stateReg.wData, stateReg.wStrb);
                end else if (wrOff == tcc_pkg::OFF_CMP_D) begin
                    stateNext.cmpD[c] = mergeLanes(stateReg.cmpD[c],
                        stateReg.wData, stateReg.wStrb);
                end else if (wrOff == tcc_pkg::OFF_CTRL
                    && stateReg.wStrb[0]) begin
                    stateNext.bufA[c] =
                        stateReg.wData[tcc_pkg::CTRL_BUF_A_BIT]; // R16
                    stateNext.bufB[c] =
                        stateReg.wData[tcc_pkg::CTRL_BUF_B_BIT]; // R16
                    stateNext.clrSel[c] =
                        stateReg.wData[tcc_pkg::CTRL_CLR_LSB+:tcc_pkg::CLR_W];
                end
            end
            // A new event in the clearing cycle keeps its flag set
            stateNext.flags[c] = (stateReg.flags[c] & ~clrMask)
                | evt; // R7 R9 R10 R11 R12 R13
            stateNext.seen[c] = (stateReg.seen[c] & ~clrMask)
                | (chRd ? stateReg.flags[c] : '0); // R8
            stateNext.irq[c] = |(stateNext.flags[c]
                & stateNext.irqEn[c]); // R2 R3 R4 R5 R6 R21
        end
        stateNext.awRdy = !stateNext.awHeld && !stateNext.bValid;
        stateNext.wRdy = !stateNext.wHeld && !stateNext.bValid;
        stateNext.arRdy = !stateNext.rValid;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stateReg <= ST_RESET; // R14 R15
        end else begin
            stateReg <= stateNext;
        end
    end

    assign s_axi_awready = stateReg.awRdy;
    assign s_axi_wready = stateReg.wRdy;
    assign s_axi_bvalid = stateReg.bValid;
    assign s_axi_bresp = stateReg.bResp;
    assign s_axi_arready = stateReg.arRdy;
    assign s_axi_rvalid = stateReg.rValid;
    assign s_axi_rresp = stateReg.rResp;
    assign s_axi_rdata = stateReg.rData;
    assign channelIrq = stateReg.irq;
    assign channelRun = stateReg.run;
    assign channelEvent = stateReg.events;

    // Checks on channel 0, apart from the reserved-bit read check, which covers every channel
    logic tick0, wr0;
    logic [2:0] rdOffQ;
    assign tick0 = stateReg.run[0] && countTick;
    assign wr0 = doWr && !wrGlobal && wrOk && wrCh == 2'h0;
    assign rdOffQ = stateReg.arAddr[tcc_pkg::CH_LSB-1:tcc_pkg::OFF_LSB];

    default clocking cbCheck @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_rsvd_read_zero: assert property (stateReg.rValid // R1
        && !stateReg.arAddr[tcc_pkg::GLOBAL_BIT]
        && (rdOffQ == tcc_pkg::OFF_IRQ_EN || rdOffQ == tcc_pkg::OFF_FLAGS)
        |-> stateReg.rData[31:tcc_pkg::FLAG_W] == '0)
        else $error("reserved bits read nonzero");
    a_irq_gating: assert property ( // R21
        stateReg.irq[0] == |(stateReg.flags[0] & stateReg.irqEn[0]))
        else $error("interrupt does not follow enabled flags");
    a_irq_overflow: assert property (stateReg.flags[0] == 5'h10 // R2
        |-> stateReg.irq[0] == stateReg.irqEn[0][tcc_pkg::BIT_OVERFLOW])
        else $error("overflow enable gating wrong");
    a_overflow_set: assert property (tick0 // R7
        && stateReg.cnt[0] == tcc_pkg::COUNTER_TOP
        && stateReg.clrSel[0] == tcc_pkg::CLR_NONE && !wr0
        |=> stateReg.flags[0][tcc_pkg::BIT_OVERFLOW]
        && stateReg.cnt[0] == tcc_pkg::COUNTER_RESET)
        else $error("wrap did not set overflow flag");
    a_match_a_set: assert property (tick0 // R12
        && stateReg.cnt[0] == stateReg.cmpA[0]
        |=> stateReg.flags[0][tcc_pkg::BIT_MATCH_A])
        else $error("match A flag not set");
    a_flag_clear_read: assert property ( // R8
        $fell(stateReg.flags[0][tcc_pkg::BIT_OVERFLOW])
        |-> $past(stateReg.seen[0][tcc_pkg::BIT_OVERFLOW]) && $past(wr0))
        else $error("overflow flag cleared without read");
    a_flag_rise_cause: assert property ( // R13
        $rose(stateReg.flags[0][tcc_pkg::BIT_MATCH_B])
        |-> $past(tick0) && $past(stateReg.cnt[0] == stateReg.cmpB[0]))
        else $error("match B flag set without match");
    a_count_hold: assert property (!stateReg.run[0] && !wr0 // R18
        |=> $stable(stateReg.cnt[0]))
        else $error("stopped counter moved");
    a_match_clear: assert property (tick0 // R19
        && stateReg.clrSel[0] == tcc_pkg::CLR_BY_B
        && stateReg.cnt[0] == stateReg.cmpB[0] && !wr0
        |=> stateReg.cnt[0] == tcc_pkg::COUNTER_RESET)
        else $error("counter not cleared by match");
    a_buffer_copy: assert property (tick0 && stateReg.bufA[0] // R20
        && stateReg.cnt[0] == stateReg.cmpA[0]
        && !wr0 |=> stateReg.cmpA[0] == $past(stateReg.cmpC[0]))
        else $error("buffer C not copied into A");
    a_reset_values: assert property ($past(!rst_n) && rst_n // R14 R15
        |-> stateReg.cnt[0] == tcc_pkg::COUNTER_RESET
        && stateReg.cmpD[0] == tcc_pkg::COMPARE_RESET)
        else $error("reset values wrong");

    c_overflow: cover property (
        $rose(stateReg.flags[0][tcc_pkg::BIT_OVERFLOW]));
    c_flag_cleared: cover property (
        $fell(stateReg.flags[0][tcc_pkg::BIT_MATCH_A]));
    c_buffer_move: cover property (tick0 && stateReg.bufB[0]
        && stateReg.cnt[0] == stateReg.cmpB[0]);
    c_irq_raised: cover property ($rose(stateReg.irq[0]));
endmodule

// ==== verification/tcc_timer_tb.sv ====
// Self-checking bench for the timer flag, enable and compare block
`timescale 1ns/1ns
module timer_channel_flags_and_compare_regs_tb;
    logic core_clk;
    logic rst_n;
    logic countTick;
    logic [tcc_pkg::ADDR_W-1:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [tcc_pkg::ADDR_W-1:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic [3:0] channelIrq;
    logic [3:0] channelRun;
    logic [19:0] channelEvent;
    int failCount = 0;
    int numChecks = 0;
    int cycles = 0;
    logic [19:0] evSeen;
    localparam logic [1:0] OK = tcc_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = tcc_pkg::RESP_SLVERR;

    tcc_timer #(.NUM_CH(4)) i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .countTick(countTick),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .channelIrq(channelIrq),
        .channelRun(channelRun), .channelEvent(channelEvent)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic endSim();
        $display("checks=%0d mismatches=%0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Ceiling is far above the few hundred cycles the sequence needs
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failCount++;
            endSim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        logic awDone;
        logic wDone;
        awDone = 1'b0;
        wDone = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge core_clk);
            if (s_axi_awready) awDone = 1'b1;
            if (s_axi_wready) wDone = 1'b1;
            if (awDone) s_axi_awvalid <= 1'b0;
            if (wDone) s_axi_wvalid <= 1'b0;
        end
        do @(posedge core_clk); while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
            input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask

    // One count enable every other cycle so the counter value is known exactly
    // Event pulses last one cycle, so they are gathered as they pass
    task automatic tick(input int n);
        evSeen = '0;
        repeat (n) begin
            countTick <= 1'b1;
            @(posedge core_clk);
            countTick <= 1'b0;
            @(posedge core_clk);
            evSeen = evSeen | channelEvent;
        end
    endtask

    task automatic chk_irq(input logic [3:0] e);
        chk({28'h0, channelIrq}, {28'h0, e});
    endtask

    task automatic t_reset_values();
        rd(8'h00, 32'h0, OK);
        rd(8'h04, 32'h0, OK);
        rd(8'h08, 32'h0, OK);
        for (int i = 3; i < 7; i++) rd(8'(i * 4), 32'h0000FFFF, OK);
        rd(8'h80, 32'h0, OK);
    endtask

    task automatic t_reserved_bits();
        wr(8'h00, 32'hFFFFFFFF, OK);
        rd(8'h00, 32'h0000001F, OK);
        wr(8'h00, 32'h0, OK);
        wr(8'h04, 32'h0000FFFF, OK);
        rd(8'h04, 32'h0, OK);
    endtask

    task automatic t_match_a();
        wr(8'h0C, 32'h2, OK);
        wr(8'h80, 32'h1, OK);
        chk({28'h0, channelRun}, 32'h1);
        tick(3);
        rd(8'h08, 32'h3, OK);
        chk({12'h0, evSeen}, 32'h1);
        chk_irq(4'h0);
        wr(8'h04, 32'h0, OK);
        rd(8'h04, 32'h1, OK);
        wr(8'h00, 32'h1, OK);
        chk_irq(4'h1);
        wr(8'h04, 32'h0, OK);
        rd(8'h04, 32'h0, OK);
        chk_irq(4'h0);
    endtask

    task automatic t_overflow();
        wr(8'h08, 32'h0000FFFE, OK);
        tick(2);
        rd(8'h08, 32'h0, OK);
        chk({12'h0, evSeen}, 32'h1E);
        rd(8'h04, 32'h1E, OK);
        for (int i = 0; i < 5; i++) begin
            wr(8'h00, 32'h1 << i, OK);
            chk_irq((i != 0) ? 4'h1 : 4'h0);
        end
        wr(8'h04, 32'h0, OK);
        rd(8'h04, 32'h0, OK);
        wr(8'h00, 32'h0, OK);
        wr(8'h80, 32'h0, OK);
        chk({28'h0, channelRun}, 32'h0);
        tick(2);
        rd(8'h08, 32'h0, OK);
    endtask

    task automatic t_periodic_and_buffer();
        wr(8'h1C, 32'h10, OK);
        wr(8'h80, 32'h1, OK);
        tick(3);
        rd(8'h08, 32'h0, OK);
        chk({12'h0, evSeen}, 32'h1);
        rd(8'h04, 32'h1, OK);
        wr(8'h04, 32'h0, OK);
        wr(8'h1C, 32'h1, OK);
        wr(8'h14, 32'h5, OK);
        wr(8'h08, 32'h0, OK);
        tick(3);
        rd(8'h0C, 32'h5, OK);
        rd(8'h10, 32'h0000FFFF, OK);
    endtask

    // Period set by B, with D feeding B at each match
    task automatic t_clear_b();
        wr(8'h1C, 32'h22, OK);
        wr(8'h10, 32'h3, OK);
        wr(8'h18, 32'h7, OK);
        wr(8'h08, 32'h0, OK);
        tick(4);
        chk({12'h0, evSeen}, 32'h2);
        rd(8'h08, 32'h0, OK);
        rd(8'h10, 32'h7, OK);
        rd(8'h0C, 32'h5, OK);
        rd(8'h04, 32'h3, OK);
        wr(8'h04, 32'h1, OK);
        rd(8'h04, 32'h1, OK);
    endtask

    task automatic t_unmapped();
        wr(8'hA0, 32'h1, ERR);
        rd(8'hA0, 32'h0, ERR);
    endtask

    initial begin
        rst_n = 1'b0;
        countTick = 1'b0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset_values();
        t_reserved_bits();
        t_match_a();
        t_overflow();
        t_periodic_and_buffer();
        t_clear_b();
        t_unmapped();
        // Reset again in mid-run: channel 0 registers other than control, and the run word, must return to their start
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset_values();
        endSim();
    end
endmodule
